// file: src/gsas_pkg.sv
// Constants, register map and alarm layout of the shutdown alarm supervisor
package gsas_pkg;
    // ------------------------------------------------------------
    // Alarm bit positions
    // ------------------------------------------------------------
    localparam int ALARM_W = 23;
    localparam int AL_ESTOP = 0;
    localparam int AL_FAIL_START = 1;
    localparam int AL_LOW_OIL = 2;
    localparam int AL_HIGH_TEMP = 3;
    localparam int AL_UNDERSPEED = 4;
    localparam int AL_OVERSPEED = 5;
    localparam int AL_PHASE_ROT = 6;
    localparam int AL_OVER_FREQ = 7;
    localparam int AL_UNDER_FREQ = 8;
    localparam int AL_OVER_VOLT = 9;
    localparam int AL_UNDER_VOLT = 10;
    localparam int AL_OIL_SENSOR = 11;
    localparam int AL_AUX0 = 12;
    localparam int AUX_N = 4;
    localparam int AL_SPEED_LOSS = 16;
    localparam int AL_ECU_DATA = 17;
    localparam int AL_ECU_SHUT = 18;
    localparam int AL_KW_OVER = 19;
    localparam int AL_HIGH_CURR = 20;
    localparam int AL_LOAD_VOLT = 21;
    localparam int AL_EARTH = 22;
    // Alarms armed only after safety-on
    localparam logic [ALARM_W-1:0] SO_MASK = 23'h20001c;
    // Alarms that a reset clears whatever the condition shows
    localparam logic [ALARM_W-1:0] RESET_ANY_MASK = 23'h20001e;
    // ------------------------------------------------------------
    // Register map (config word indices, status byte addresses)
    // ------------------------------------------------------------
    localparam int CFG_N = 16;
    localparam int CFG_CTRL = 0;
    localparam int CFG_OIL = 1;
    localparam int CFG_TEMP = 2;
    localparam int CFG_UNDERSPEED = 3;
    localparam int CFG_OVERSPEED = 4;
    localparam int CFG_OVERSHOOT = 5;
    localparam int CFG_FREQ_HI = 6;
    localparam int CFG_FREQ_LO = 7;
    localparam int CFG_VOLT_HI = 8;
    localparam int CFG_VOLT_LO = 9;
    localparam int CFG_LOAD_VOLT = 10;
    localparam int CFG_KW = 11;
    localparam int CFG_CURR = 12;
    localparam int CFG_CURR_TIME = 13;
    localparam int CFG_EARTH = 14;
    localparam int CFG_EARTH_CURVE = 15;
    localparam logic [7:0] ADDR_STATUS = 8'h40;
    localparam logic [7:0] ADDR_COND = 8'h44;
    localparam logic [7:0] ADDR_LOG = 8'h48;
    localparam logic [7:0] ADDR_ECU = 8'h4c;
    // Control word fields
    localparam int CTRL_PROT_DIS = 0;
    localparam int CTRL_HC_TRIP = 1;
    localparam int CTRL_OVERSHOOT = 2;
    localparam int CTRL_CAN_MODE = 3;
    localparam int CTRL_ROT_FWD = 4;
    localparam int CTRL_AUX_LSB = 8;
    localparam int CTRL_ATT_LSB = 16;
    localparam int ATT_W = 4;
    localparam logic [31:0] CFG_RST [0:CFG_N-1] = '{
        32'h00030010, 32'h00000000, 32'h0000ffff, 32'h00000000,
        32'h0000ffff, 32'h00000000, 32'h0000ffff, 32'h00000000,
        32'h0000ffff, 32'h00000000, 32'h00000000, 32'h0000ffff,
        32'h0000ffff, 32'h000003e8, 32'h0000ffff, 32'h00100000};
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 100000;
    localparam int SPEED_LOSS_MS = 2000;
    localparam int CAN_LOSS_MS = 3000;
    localparam int SPEED_LOSS_CYC = SPEED_LOSS_MS * CLK_KHZ;
    localparam int CAN_LOSS_CYC = CAN_LOSS_MS * CLK_KHZ;
endpackage

// file: src/gsas_supervisor.sv
// Shutdown alarm supervisor: qualification, latching, reset and APB access
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
// How it works
// - Qualified shutdown latches and stops the set
// - Latch clears only on operator stop/reset
// - Reset ignored while fault still present
// - Safety-on alarms reset despite present condition
// - Protections disabled: indicate, keep running, log
// - Fail to start after attempts used
// - Lost failsafe emergency stop stops set
// - Low oil pressure after safety-on
// - High coolant temperature after safety-on
// - Underspeed after safety-on
// - Overspeed, optional start-up margin
// - Phase rotation differs from configured direction
// - Over/under frequency and voltage shutdowns
// - Oil pressure sensor open circuit
// - Enabled auxiliary input shuts down, shown
// - No magnetic pickup pulses: speed loss
// - CAN mode, no data: ECU data fail
// - ECU shutdown with reported error shown
// - Total kW above overload setting
// - Persistent high current: shutdown or trip
// - Loading voltage not reached after safety
// - Earth fault after inverse time curve
module gsas_supervisor #(
    parameter int unsigned SPEED_LOSS_CYC = gsas_pkg::SPEED_LOSS_CYC,
    parameter int unsigned CAN_LOSS_CYC = gsas_pkg::CAN_LOSS_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic estop_ok_pin,
    input wire logic oil_sensor_open_pin,
    input wire logic mpu_pin,
    input wire logic stop_reset_pin,
    input wire logic [gsas_pkg::AUX_N-1:0] aux_pin,
    input wire logic safety_on,
    input wire logic start_sequence,
    input wire logic engine_running,
    input wire logic crank_fail,
    input wire logic engine_fired,
    input wire logic [15:0] oil_pressure,
    input wire logic [15:0] coolant_temp,
    input wire logic [15:0] engine_speed,
    input wire logic [15:0] gen_freq,
    input wire logic [15:0] gen_volt,
    input wire logic [15:0] total_kw,
    input wire logic [15:0] gen_current,
    input wire logic [15:0] earth_current,
    input wire logic phase_valid,
    input wire logic phase_forward,
    input wire logic can_frame_rx,
    input wire logic ecu_shutdown,
    input wire logic [15:0] ecu_error,
    output logic stop_cmd,
    output logic elec_trip_req,
    output logic prot_disabled_ind,
    output logic [gsas_pkg::ALARM_W-1:0] alarm_active,
    output logic [15:0] ecu_error_shown
);
    import gsas_pkg::*;

    localparam int PIN_N = 4 + AUX_N;

    logic [31:0] cfg [0:CFG_N-1];
    logic [PIN_N-1:0] pin_s1;
    logic [PIN_N-1:0] pin_s2;
    logic stop_btn_q;
    logic reset_edge;
    logic mpu_q;
    logic [ALARM_W-1:0] alarm;
    logic [ALARM_W-1:0] cond;
    logic [ALARM_W-1:0] qual;
    logic [ALARM_W-1:0] clear_ok;
    logic [ALARM_W-1:0] next_alarm;
    logic [ALARM_W-1:0] stop_mask;
    logic [ATT_W-1:0] attempts;
    logic [31:0] hc_cnt;
    logic [31:0] speed_cnt;
    logic [31:0] can_cnt;
    logic [31:0] earth_acc;
    logic [32:0] earth_sum;
    logic [16:0] os_limit;
    logic prot_dis;
    logic hc_trip;
    logic log_flag;
    logic [7:0] log_cnt;
    logic new_event;
    logic wr_en;
    logic [31:0] rd_word;
    logic rd_err;

    assign prot_dis = cfg[CFG_CTRL][CTRL_PROT_DIS];
    assign hc_trip = cfg[CFG_CTRL][CTRL_HC_TRIP];

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 8'h01;
            pin_s2 <= 8'h01;
        end else begin
            pin_s1 <= {aux_pin, stop_reset_pin, mpu_pin, oil_sensor_open_pin, estop_ok_pin};
            pin_s2 <= pin_s1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_btn_q <= 1'b0;
            mpu_q <= 1'b0;
        end else begin
            stop_btn_q <= pin_s2[3];
            mpu_q <= pin_s2[2];
        end
    end

    // Operator stop/reset press
    assign reset_edge = pin_s2[3] & ~stop_btn_q;

    // ------------------------------------------------------------
    // Condition counters
    // ------------------------------------------------------------
    // count failed attempts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            attempts <= 4'h0;
        end else if (engine_fired || reset_edge) begin
            attempts <= 4'h0;
        end else if (crank_fail && attempts != 4'hf) begin
            attempts <= attempts + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hc_cnt <= 32'h0;
        end else if (gen_current <= cfg[CFG_CURR][15:0]) begin
            hc_cnt <= 32'h0;
        end else if (hc_cnt < cfg[CFG_CURR_TIME]) begin
            hc_cnt <= hc_cnt + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_cnt <= 32'h0;
        end else if (!engine_running || (pin_s2[2] && !mpu_q)) begin
            speed_cnt <= 32'h0;
        end else if (speed_cnt < SPEED_LOSS_CYC) begin
            speed_cnt <= speed_cnt + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            can_cnt <= 32'h0;
        end else if (!cfg[CFG_CTRL][CTRL_CAN_MODE] || can_frame_rx) begin
            can_cnt <= 32'h0;
        end else if (can_cnt < CAN_LOSS_CYC) begin
            can_cnt <= can_cnt + 32'h1;
        end
    end

    // inverse time integral of excess earth current
    assign earth_sum = {1'b0, earth_acc} + {17'h0, earth_current - cfg[CFG_EARTH][15:0]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            earth_acc <= 32'h0;
        end else if (earth_current <= cfg[CFG_EARTH][15:0]) begin
            earth_acc <= 32'h0;
        end else begin
            earth_acc <= earth_sum[32] ? 32'hffffffff : earth_sum[31:0];
        end
    end

    assign os_limit = {1'b0, cfg[CFG_OVERSPEED][15:0]}
        + ((cfg[CFG_CTRL][CTRL_OVERSHOOT] && start_sequence)
           ? {1'b0, cfg[CFG_OVERSHOOT][15:0]} : 17'h0);

    // ------------------------------------------------------------
    // Raw shutdown conditions
    // ------------------------------------------------------------
    // failsafe input lost
    assign cond[AL_ESTOP] = ~pin_s2[0];
    assign cond[AL_FAIL_START] = (cfg[CFG_CTRL][CTRL_ATT_LSB +: ATT_W] != 4'h0)
        && (attempts >= cfg[CFG_CTRL][CTRL_ATT_LSB +: ATT_W]);
    assign cond[AL_LOW_OIL] = oil_pressure < cfg[CFG_OIL][15:0];
    assign cond[AL_HIGH_TEMP] = coolant_temp > cfg[CFG_TEMP][15:0];
    assign cond[AL_UNDERSPEED] = engine_speed < cfg[CFG_UNDERSPEED][15:0];
    assign cond[AL_OVERSPEED] = {1'b0, engine_speed} > os_limit;
    assign cond[AL_PHASE_ROT] = phase_valid && (phase_forward != cfg[CFG_CTRL][CTRL_ROT_FWD]);
    assign cond[AL_OVER_FREQ] = gen_freq > cfg[CFG_FREQ_HI][15:0];
    assign cond[AL_UNDER_FREQ] = gen_freq < cfg[CFG_FREQ_LO][15:0];
    assign cond[AL_OVER_VOLT] = gen_volt > cfg[CFG_VOLT_HI][15:0];
    assign cond[AL_UNDER_VOLT] = gen_volt < cfg[CFG_VOLT_LO][15:0];
    assign cond[AL_OIL_SENSOR] = pin_s2[1];
    assign cond[AL_AUX0 +: AUX_N] = pin_s2[4 +: AUX_N] & cfg[CFG_CTRL][CTRL_AUX_LSB +: AUX_N];
    assign cond[AL_SPEED_LOSS] = speed_cnt >= SPEED_LOSS_CYC;
    assign cond[AL_ECU_DATA] = can_cnt >= CAN_LOSS_CYC;
    assign cond[AL_ECU_SHUT] = ecu_shutdown;
    assign cond[AL_KW_OVER] = total_kw > cfg[CFG_KW][15:0];
    assign cond[AL_HIGH_CURR] = (gen_current > cfg[CFG_CURR][15:0])
        && (hc_cnt >= cfg[CFG_CURR_TIME]);
    assign cond[AL_LOAD_VOLT] = gen_volt <= cfg[CFG_LOAD_VOLT][15:0];
    assign cond[AL_EARTH] = earth_acc >= cfg[CFG_EARTH_CURVE];

    // ------------------------------------------------------------
    // Latching and reset
    // ------------------------------------------------------------
    // armed alarms only qualify with safety-on
    assign qual = cond & (safety_on ? {ALARM_W{1'b1}} : ~SO_MASK);
    // a present fault blocks its reset, except alarms in RESET_ANY_MASK
    assign clear_ok = ~cond | RESET_ANY_MASK;
    assign next_alarm = (alarm & ~(reset_edge ? clear_ok : {ALARM_W{1'b0}})) | qual;
    // configured trip mode leaves high current to the trip output
    assign stop_mask = ~({{(ALARM_W-1){1'b0}}, hc_trip} << AL_HIGH_CURR);
    assign new_event = |(qual & ~alarm);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm <= {ALARM_W{1'b0}};
        end else begin
            alarm <= next_alarm;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_cmd <= 1'b0;
            elec_trip_req <= 1'b0;
            prot_disabled_ind <= 1'b0;
        end else begin
            stop_cmd <= (|(next_alarm & stop_mask)) && !prot_dis;
            elec_trip_req <= next_alarm[AL_HIGH_CURR] && hc_trip && !prot_dis;
            prot_disabled_ind <= prot_dis && (|next_alarm);
        end
    end

    assign alarm_active = alarm;

    // log events while protections are disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_flag <= 1'b0;
            log_cnt <= 8'h00;
        end else begin
            if (prot_dis && new_event) begin
                log_flag <= 1'b1;
            end else if (wr_en && paddr == ADDR_LOG && pwdata[0]) begin
                log_flag <= 1'b0;
            end
            if (prot_dis && new_event && log_cnt != 8'hff) begin
                log_cnt <= log_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ecu_error_shown <= 16'h0000;
        end else if (qual[AL_ECU_SHUT] && !alarm[AL_ECU_SHUT]) begin
            ecu_error_shown <= ecu_error;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign pready = penable;
    assign wr_en = psel && penable && pwrite && !pslverr;

    always_comb begin
        rd_word = 32'h0;
        rd_err = 1'b0;
        if (paddr[1:0] != 2'b00) begin
            rd_err = 1'b1;
        end else if (paddr < ADDR_STATUS) begin
            rd_word = cfg[paddr[5:2]];
        end else begin
            case (paddr)
                ADDR_STATUS: rd_word = {9'h0, alarm};
                ADDR_COND: rd_word = {9'h0, cond};
                ADDR_LOG: rd_word = {16'h0, log_cnt, 7'h0, log_flag};
                ADDR_ECU: rd_word = {16'h0, ecu_error_shown};
                default: rd_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0 : rd_word;
            pslverr <= rd_err;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < CFG_N; i++) begin
                cfg[i] <= CFG_RST[i];
            end
        end else if (wr_en && paddr < ADDR_STATUS) begin
            cfg[paddr[5:2]] <= pwdata;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_estop_lost;
        (!estop_ok_pin && !prot_dis)[*4];
    endsequence

    sequence s_reset_blocked;
        reset_edge && (|(alarm & cond & ~RESET_ANY_MASK));
    endsequence

    property p_latch;
        @(posedge pclk) disable iff (!presetn)
        (qual != 0) |=> ((alarm & $past(qual)) == $past(qual));
    endproperty
    a_latch: assert property (p_latch) else $error("qualified alarm not latched");

    property p_clear_cause;
        @(posedge pclk) disable iff (!presetn)
        (|($past(alarm) & ~alarm)) |-> $past(reset_edge);
    endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("alarm cleared without reset");

    property p_blocked;
        @(posedge pclk) disable iff (!presetn)
        s_reset_blocked |=> ((alarm & $past(alarm & cond & ~RESET_ANY_MASK))
                             == $past(alarm & cond & ~RESET_ANY_MASK));
    endproperty
    a_blocked: assert property (p_blocked) else $error("reset cleared present fault");

    property p_so_reset;
        @(posedge pclk) disable iff (!presetn)
        (reset_edge && qual == 0) |=> ((alarm & SO_MASK) == 0);
    endproperty
    a_so_reset: assert property (p_so_reset) else $error("safety-on alarm not reset");

    property p_prot_dis;
        @(posedge pclk) disable iff (!presetn)
        $past(prot_dis) && prot_dis |-> !stop_cmd && (prot_disabled_ind == (|alarm));
    endproperty
    a_prot_dis: assert property (p_prot_dis) else $error("disabled protection stopped set");

    property p_estop;
        @(posedge pclk) disable iff (!presetn)
        s_estop_lost |-> ##[0:1] (stop_cmd && alarm[AL_ESTOP]);
    endproperty
    a_estop: assert property (p_estop) else $error("emergency stop not acted on");

    property p_oil_gate;
        @(posedge pclk) disable iff (!presetn)
        !safety_on |-> !qual[AL_LOW_OIL] && !qual[AL_HIGH_TEMP]
                       && !qual[AL_UNDERSPEED] && !qual[AL_LOAD_VOLT];
    endproperty
    a_oil_gate: assert property (p_oil_gate) else $error("armed alarm before safety-on");

    property p_overspeed;
        @(posedge pclk) disable iff (!presetn)
        ({1'b0, engine_speed} > os_limit) |=> alarm[AL_OVERSPEED];
    endproperty
    a_overspeed: assert property (p_overspeed) else $error("overspeed not latched");

    property p_hc_mode;
        @(posedge pclk) disable iff (!presetn)
        alarm[AL_HIGH_CURR] && !prot_dis && $stable(cfg[CFG_CTRL]) |->
            (elec_trip_req == hc_trip);
    endproperty
    a_hc_mode: assert property (p_hc_mode) else $error("high current mode wrong");

    property p_earth;
        @(posedge pclk) disable iff (!presetn)
        (earth_acc >= cfg[CFG_EARTH_CURVE]) |=> alarm[AL_EARTH];
    endproperty
    a_earth: assert property (p_earth) else $error("earth fault not latched");

    property p_fail_start;
        @(posedge pclk) disable iff (!presetn)
        cond[AL_FAIL_START] |=> alarm[AL_FAIL_START];
    endproperty
    a_fail_start: assert property (p_fail_start) else $error("fail to start not latched");
endmodule

// file: verification/gsas_partner.sv
// Far side model: engine pins, pickup, datalink and operator panel
`timescale 1ns/1ps
module gsas_partner (
    input wire logic pclk,
    input wire logic press,
    input wire logic estop_hit,
    input wire logic pulses_on,
    input wire logic sensor_open,
    output logic estop_ok_pin = 1'b1,
    output logic oil_sensor_open_pin = 1'b0,
    output logic mpu_pin = 1'b0,
    output logic stop_reset_pin = 1'b0,
    output logic can_frame_rx = 1'b0
);
    logic [2:0] ph = 3'h0;
    always @(posedge pclk) begin
        ph <= ph + 3'h1;
        // operator press held as a level
        stop_reset_pin <= press;
        estop_ok_pin <= !estop_hit;
        oil_sensor_open_pin <= sensor_open;
        // Pickup and frames only while pulses_on
        mpu_pin <= pulses_on & ph[1];
        can_frame_rx <= pulses_on & (ph == 3'h7);
    end
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the shutdown alarm supervisor
`timescale 1ns/1ps
module tb_top;
    import gsas_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h1a33d5c3;
    logic pready, pslverr, estop_ok_pin, oil_sensor_open_pin, mpu_pin, stop_reset_pin;
    logic can_frame_rx, stop_cmd, elec_trip_req, prot_disabled_ind;
    logic [AUX_N-1:0] aux_pin;
    logic safety_on, start_sequence, engine_running, crank_fail, engine_fired;
    logic [15:0] oil_pressure, coolant_temp, engine_speed, gen_freq, gen_volt;
    logic [15:0] total_kw, gen_current, earth_current, ecu_error, ecu_error_shown;
    logic phase_valid, phase_forward, ecu_shutdown;
    logic [ALARM_W-1:0] alarm_active;
    logic press = 1'b0, estop_hit = 1'b0, pulses_on = 1'b0, sensor_open = 1'b0;
    int n_errors = 0, compares = 0;

    gsas_supervisor #(.SPEED_LOSS_CYC(20), .CAN_LOSS_CYC(30)) uut (.*);
    gsas_partner peer (.*);

    initial begin
        forever #5 pclk = ~pclk;
    end

    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function logic [31:0] al(input int b);
        return 32'h1 << b;
    endfunction
    function logic [31:0] fs_exp(input int n, input logic [31:0] c);
        return (c[19:16] != 4'h0 && n >= c[19:16]) ? al(AL_FAIL_START) : 32'h0;
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task ca(input logic [31:0] exp);
        chk({9'h000, alarm_active}, exp);
    endtask
    task see(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Quiet plant with random in-range readings
    task calm();
        seed = lfsr(seed);
        aux_pin <= 4'h0;
        safety_on <= 1'b0;
        start_sequence <= seed[0];
        engine_running <= 1'b0;
        crank_fail <= 1'b0;
        engine_fired <= 1'b0;
        oil_pressure <= seed[31:16];
        coolant_temp <= seed[15:0];
        engine_speed <= seed[31:16];
        gen_freq <= 16'h1000;
        gen_volt <= 16'h1000;
        total_kw <= seed[15:0];
        gen_current <= seed[15:0];
        earth_current <= seed[31:16];
        phase_valid <= 1'b1;
        phase_forward <= 1'b1;
        ecu_shutdown <= 1'b0;
        ecu_error <= seed[15:0];
        press <= 1'b0;
        estop_hit <= 1'b0;
        pulses_on <= 1'b0;
        sensor_open <= 1'b0;
    endtask
    task rst();
        @(posedge pclk);
        presetn <= 1'b0;
        calm();
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task hit();
        @(posedge pclk);
        press <= 1'b1;
        repeat (6) @(posedge pclk);
        press <= 1'b0;
        see(4);
    endtask
    task meas(input int i, input logic [15:0] v);
        @(posedge pclk);
        if (i < 2) gen_freq <= v;
        else gen_volt <= v;
    endtask
    task summarize();
        $display("Comparisons %0d, errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        summarize();
    end

    initial begin
        int i;
        logic [15:0] v;
        calm();
        rst();
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h00030010);
        apb(1'b1, 8'h3c, seed);
        apb(1'b0, 8'h3c, 32'h0);
        chk(rd, seed);
        apb(1'b0, 8'h50, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Trip, hold, refused reset, accepted reset
        for (i = 0; i < 4; i++) begin
            rst();
            apb(1'b1, 8'h18 + 8'(4 * i), 32'h1000);
            v = i[0] ? {4'h0, seed[11:0]} : 16'h1001 + {4'h0, seed[11:0]};
            meas(i, v);
            see(1);
            ca(al(AL_OVER_FREQ + i));
            chk({31'h0, stop_cmd}, 32'h1);
            meas(i, 16'h1000);
            see(3);
            ca(al(AL_OVER_FREQ + i));
            meas(i, v);
            hit();
            ca(al(AL_OVER_FREQ + i));
            meas(i, 16'h1000);
            hit();
            ca(32'h0);
            chk({31'h0, stop_cmd}, 32'h0);
        end
        rst();
        apb(1'b1, 8'h04, 32'h0100);
        @(posedge pclk);
        oil_pressure <= {8'h00, seed[7:0]};
        see(3);
        ca(32'h0);
        @(posedge pclk);
        safety_on <= 1'b1;
        see(1);
        ca(al(AL_LOW_OIL));
        @(posedge pclk);
        safety_on <= 1'b0;
        hit();
        ca(32'h0);
        @(posedge pclk);
        estop_hit <= 1'b1;
        see(4);
        ca(al(AL_ESTOP));
        chk({31'h0, stop_cmd}, 32'h1);
        rst();
        apb(1'b1, 8'h00, 32'h00030011);
        apb(1'b1, 8'h2c, 32'h0010);
        @(posedge pclk);
        total_kw <= 16'h0011 + {8'h00, seed[7:0]};
        see(1);
        ca(al(AL_KW_OVER));
        chk({30'h0, stop_cmd, prot_disabled_ind}, 32'h1);
        apb(1'b0, 8'h48, 32'h0);
        chk({31'h0, rd[0]}, 32'h1);
        rst();
        apb(1'b1, 8'h00, 32'h00030018);
        @(posedge pclk);
        engine_running <= 1'b1;
        pulses_on <= 1'b1;
        see(60);
        ca(32'h0);
        @(posedge pclk);
        pulses_on <= 1'b0;
        see(60);
        ca(al(AL_SPEED_LOSS) | al(AL_ECU_DATA));
        rst();
        for (i = 1; i <= 3; i++) begin
            @(posedge pclk);
            crank_fail <= 1'b1;
            @(posedge pclk);
            crank_fail <= 1'b0;
            see(1);
            ca(fs_exp(i, 32'h00030010));
        end
        rst();
        @(posedge pclk);
        ecu_shutdown <= 1'b1;
        see(1);
        ca(al(AL_ECU_SHUT));
        chk({16'h0, ecu_error_shown}, {16'h0, ecu_error});
        rst();
        apb(1'b1, 8'h00, 32'h00030410);
        @(posedge pclk);
        aux_pin <= 4'hf;
        sensor_open <= 1'b1;
        phase_forward <= 1'b0;
        see(5);
        ca(al(AL_OIL_SENSOR) | al(AL_AUX0 + 2) | al(AL_PHASE_ROT));
        // High current in trip mode, earth curve, loading voltage
        rst();
        gen_current <= 16'h0000;
        earth_current <= 16'h0000;
        apb(1'b1, 8'h00, 32'h00030012);
        apb(1'b1, 8'h30, 32'h0010);
        apb(1'b1, 8'h34, 32'h0002);
        apb(1'b1, 8'h38, 32'h0010);
        apb(1'b1, 8'h3c, 32'h0040);
        apb(1'b1, 8'h28, 32'h2000);
        @(posedge pclk);
        gen_current <= 16'h0011 + {8'h00, seed[7:0]};
        earth_current <= 16'h0020;
        see(3);
        ca(al(AL_HIGH_CURR));
        chk({30'h0, stop_cmd, elec_trip_req}, 32'h1);
        see(3);
        ca(al(AL_HIGH_CURR) | al(AL_EARTH));
        chk({30'h0, stop_cmd, elec_trip_req}, 32'h3);
        @(posedge pclk);
        safety_on <= 1'b1;
        see(1);
        ca(al(AL_HIGH_CURR) | al(AL_EARTH) | al(AL_LOAD_VOLT));
        summarize();
    end
endmodule
